// ### shared/lupc_pkg.sv
// Constants and carrier types for the LCD and UART pin configuration block
// ============================================================
package lupc_pkg;
    // ============================================================
    // Register map
    localparam logic [31:0] LCD_CONF_ADDR = 32'h4000_4054;
    localparam logic [31:0] UART_CTL_ADDR = 32'h4005_4000;
    localparam logic [8:0] LCD_CONF_MASK = 9'h1ff;
    localparam logic [11:0] UART_CTL_MASK = 12'he3f;
    localparam logic [11:0] UART_CTL_RESET = 12'h000;
    localparam logic [8:0] LCD_CONF_RESET = 9'h000;
    // ============================================================
    // Field positions
    localparam int LCD_STN_BIT = 8;
    localparam int LCD_GRP_LSB = 6;
    localparam int LCD_HCLK_BIT = 5;
    localparam int LCD_DIV_LSB = 0;
    localparam int U3_MODEM_BIT = 11;
    localparam int HDX_INV_BIT = 10;
    localparam int HDX_EN_BIT = 9;
    localparam int U6_BYP_BIT = 5;
    localparam int IR_TXINV_BIT = 4;
    localparam int IR_RXINV_BIT = 3;
    localparam int IR_RXLEN_BIT = 2;
    localparam int IR_TXLEN_BIT = 1;
    localparam int U5_USB_BIT = 0;
    // ============================================================
    // Infrared timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int IR_FIX_PULSE_NS = 1627;
    localparam logic [4:0] IR_FIX_CYC = 5'(IR_FIX_PULSE_NS / CLK_PERIOD_NS);
    localparam logic [4:0] IR_FIX_MIN = IR_FIX_CYC >> 1;
    localparam logic [4:0] IR_SEL_TICKS = 5'h03;
    localparam logic [3:0] IR_BIT_TICKS_M1 = 4'hf;
    localparam logic [4:0] ZERO5 = 5'h00;
    localparam logic [4:0] ONE5 = 5'h01;
    // ============================================================
    // Types
    typedef enum logic [2:0] {
        LUPC_TFT_12 = 3'b000,
        LUPC_TFT_565 = 3'b001,
        LUPC_TFT_1555 = 3'b010,
        LUPC_TFT_24 = 3'b011,
        LUPC_STN_4 = 3'b100,
        LUPC_STN_8 = 3'b101,
        LUPC_STN_D4 = 3'b110,
        LUPC_STN_D8 = 3'b111
    } lupc_lcd_mode_t;
    typedef struct packed {
        lupc_lcd_mode_t mode;
        logic [4:0] pin_count;
        logic bus_clk_en;
        logic [4:0] prescale;
    } lupc_lcd_out_t;
    typedef struct packed {
        logic dtr;
        logic rts;
        logic dsr;
        logic cts;
        logic dcd;
        logic ri;
    } lupc_modem_t;
endpackage : lupc_pkg

// ### core/lupc_core.sv
// LCD and UART pin configuration registers with routing and infrared logic
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
module lupc_core (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output lupc_pkg::lupc_lcd_out_t lcd_out,
    output logic lcd_pin_override,
    output logic lcd_bus_clk,
    input wire logic panel_src_tick,
    output logic panel_clk_tick,
    input wire lupc_pkg::lupc_modem_t u3_core_modem,
    input wire lupc_pkg::lupc_modem_t u3_pin_modem,
    output lupc_pkg::lupc_modem_t u3_to_core,
    output lupc_pkg::lupc_modem_t u3_to_pin,
    output logic u3_modem_oe_n,
    input wire logic u6_txd,
    input wire logic u6_baud16_tick,
    input wire logic u6_ir_rx_pin,
    output logic u6_ir_tx_pin,
    output logic u6_rxd,
    input wire logic u5_txd,
    input wire logic u5_receive_pin,
    input wire logic usb_dm_in,
    output logic u5_transmit_pin,
    output logic u5_rxd,
    output logic usb_dp_out,
    output logic usb_dp_oe_n
);
    // ============================================================
    // Register file
    logic [8:0] lcd_reg;
    logic [11:0] uart_reg;
    logic [31:0] prdata_reg;
    logic hit_lcd;
    logic hit_uart;
    logic wr_stb;

    assign hit_lcd = (paddr == lupc_pkg::LCD_CONF_ADDR);
    assign hit_uart = (paddr == lupc_pkg::UART_CTL_ADDR);
    assign wr_stb = psel & penable & pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~(hit_lcd | hit_uart);
    assign prdata = prdata_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lcd_reg <= lupc_pkg::LCD_CONF_RESET;
        end else if (wr_stb && hit_lcd) begin
            lcd_reg <= pwdata[8:0] & lupc_pkg::LCD_CONF_MASK;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            uart_reg <= lupc_pkg::UART_CTL_RESET;
        end else if (wr_stb && hit_uart) begin
            uart_reg <= pwdata[11:0] & lupc_pkg::UART_CTL_MASK;
        end
    end

    // Read data latched in the setup cycle, reserved bits read zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable) begin
            if (hit_lcd) begin
                prdata_reg <= {23'h000000, lcd_reg};
            end else if (hit_uart) begin
                prdata_reg <= {20'h00000, uart_reg};
            end else begin
                prdata_reg <= 32'h0000_0000;
            end
        end
    end

    // ============================================================
    // LCD pin group decode
    function automatic logic [4:0] pin_count_f(input logic [2:0] m);
        logic [4:0] c;
        c = 5'h00;
        case (m)
            3'b000: c = 5'h12;
            3'b001: c = 5'h16;
            3'b010: c = 5'h18;
            3'b011: c = 5'h1e;
            3'b100: c = 5'h0a;
            3'b101: c = 5'h0e;
            3'b110: c = 5'h0e;
            3'b111: c = 5'h16;
            default: c = 5'h00;
        endcase
        return c;
    endfunction : pin_count_f

    logic [2:0] mode_sel;
    logic hclk_gate_reg;
    assign mode_sel = lcd_reg[lupc_pkg::LCD_STN_BIT:lupc_pkg::LCD_GRP_LSB];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lcd_out <= '0;
            lcd_pin_override <= 1'b0;
        end else begin
            lcd_out.mode <= lupc_pkg::lupc_lcd_mode_t'(mode_sel);
            lcd_out.pin_count <= pin_count_f(mode_sel);
            lcd_out.bus_clk_en <= lcd_reg[lupc_pkg::LCD_HCLK_BIT];
            lcd_out.prescale <= lcd_reg[lupc_pkg::LCD_DIV_LSB +: 5];
            lcd_pin_override <= 1'b1;
        end
    end

    // Gate enable changes while the clock is low, so no glitch
    always_ff @(negedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hclk_gate_reg <= 1'b0;
        end else begin
            hclk_gate_reg <= lcd_out.bus_clk_en;
        end
    end
    assign lcd_bus_clk = clk_sys & hclk_gate_reg;

    // ============================================================
    // Panel clock prescaler
    logic [4:0] div_cnt_reg;
    logic div_wrap;
    assign div_wrap = (div_cnt_reg >= lcd_out.prescale);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_reg <= lupc_pkg::ZERO5;
            panel_clk_tick <= 1'b0;
        end else begin
            panel_clk_tick <= panel_src_tick & div_wrap;
            if (panel_src_tick) begin
                div_cnt_reg <= div_wrap ? lupc_pkg::ZERO5
                                        : div_cnt_reg + lupc_pkg::ONE5;
            end
        end
    end

    // ============================================================
    // UART3 modem pins
    localparam lupc_pkg::lupc_modem_t MODEM_IDLE = '1;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            u3_to_core <= MODEM_IDLE;
            u3_to_pin <= MODEM_IDLE;
            u3_modem_oe_n <= 1'b1;
        end else if (uart_reg[lupc_pkg::U3_MODEM_BIT]) begin
            u3_to_core <= u3_pin_modem;
            u3_to_pin <= u3_core_modem;
            u3_modem_oe_n <= 1'b0;
        end else begin
            u3_to_core <= MODEM_IDLE;
            u3_to_pin <= MODEM_IDLE;
            u3_modem_oe_n <= 1'b1;
        end
    end

    // ============================================================
    // UART6 infrared receive conditioning
    logic ir_rx_cond;
    logic ir_rx_lvl;
    assign ir_rx_lvl = u6_ir_rx_pin ^ uart_reg[lupc_pkg::IR_RXINV_BIT]
                       ^ uart_reg[lupc_pkg::HDX_INV_BIT];
    assign ir_rx_cond = (uart_reg[lupc_pkg::HDX_EN_BIT] & ~u6_txd)
                        ? 1'b1 : ir_rx_lvl;

    // Demodulator: a low pulse of enough width gives one low bit
    logic [4:0] rx_wid_reg;
    logic [4:0] rx_hold_reg;
    logic rx_accept;
    logic [4:0] rx_min;
    logic rx_step;
    assign rx_min = uart_reg[lupc_pkg::IR_RXLEN_BIT] ? lupc_pkg::IR_FIX_MIN
                                                     : lupc_pkg::ONE5;
    assign rx_step = uart_reg[lupc_pkg::IR_RXLEN_BIT] ? 1'b1
                                                      : u6_baud16_tick;
    assign rx_accept = (rx_wid_reg == rx_min);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_wid_reg <= lupc_pkg::ZERO5;
        end else if (ir_rx_cond) begin
            rx_wid_reg <= lupc_pkg::ZERO5;
        end else if (rx_step && !rx_accept) begin
            rx_wid_reg <= rx_wid_reg + lupc_pkg::ONE5;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_hold_reg <= lupc_pkg::ZERO5;
        end else if (rx_accept && rx_step && !ir_rx_cond
                     && rx_hold_reg == lupc_pkg::ZERO5) begin
            rx_hold_reg <= {1'b0, lupc_pkg::IR_BIT_TICKS_M1};
        end else if (u6_baud16_tick && rx_hold_reg != lupc_pkg::ZERO5) begin
            rx_hold_reg <= rx_hold_reg - lupc_pkg::ONE5;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            u6_rxd <= 1'b1;
        end else if (uart_reg[lupc_pkg::U6_BYP_BIT]) begin
            u6_rxd <= ir_rx_cond;
        end else begin
            u6_rxd <= (rx_hold_reg == lupc_pkg::ZERO5);
        end
    end

    // ============================================================
    // UART6 infrared modulator
    logic [3:0] tx_phase_reg;
    logic txd_d_reg;
    logic [4:0] tx_pulse_reg;
    logic tx_start;
    logic tx_step;
    assign tx_start = u6_baud16_tick & ~u6_txd
                      & (tx_phase_reg == 4'h0);
    assign tx_step = uart_reg[lupc_pkg::IR_TXLEN_BIT] ? 1'b1
                                                      : u6_baud16_tick;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            txd_d_reg <= 1'b1;
            tx_phase_reg <= 4'h0;
        end else begin
            txd_d_reg <= u6_txd;
            if (u6_txd != txd_d_reg) begin
                tx_phase_reg <= 4'h0;
            end else if (u6_baud16_tick) begin
                tx_phase_reg <= tx_phase_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_pulse_reg <= lupc_pkg::ZERO5;
        end else if (tx_start && tx_pulse_reg == lupc_pkg::ZERO5) begin
            tx_pulse_reg <= uart_reg[lupc_pkg::IR_TXLEN_BIT]
                            ? lupc_pkg::IR_FIX_CYC
                            : lupc_pkg::IR_SEL_TICKS;
        end else if (tx_step && tx_pulse_reg != lupc_pkg::ZERO5) begin
            tx_pulse_reg <= tx_pulse_reg - lupc_pkg::ONE5;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            u6_ir_tx_pin <= 1'b0;
        end else if (uart_reg[lupc_pkg::U6_BYP_BIT]) begin
            u6_ir_tx_pin <= u6_txd
                            ^ uart_reg[lupc_pkg::IR_TXINV_BIT];
        end else begin
            u6_ir_tx_pin <= (tx_pulse_reg != lupc_pkg::ZERO5)
                            ^ uart_reg[lupc_pkg::IR_TXINV_BIT];
        end
    end

    // ============================================================
    // UART5 routing to USB pins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            u5_transmit_pin <= 1'b1;
            u5_rxd <= 1'b1;
            usb_dp_out <= 1'b1;
            usb_dp_oe_n <= 1'b1;
        end else begin
            u5_transmit_pin <= u5_txd;
            usb_dp_out <= u5_txd;
            usb_dp_oe_n <= ~uart_reg[lupc_pkg::U5_USB_BIT];
            u5_rxd <= uart_reg[lupc_pkg::U5_USB_BIT]
                      ? (u5_receive_pin & usb_dm_in) : u5_receive_pin;
        end
    end

    // ============================================================
    // Assertions
    property p_lcd_mode;
        @(posedge clk_sys) disable iff (!rst_n)
        (wr_stb && hit_lcd) |=> ##1
        (lcd_out.mode == lupc_pkg::lupc_lcd_mode_t'($past(pwdata[8:6], 2)));
    endproperty
    a_lcd_mode: assert property (p_lcd_mode)
        else $error("lcd mode does not follow write");

    property p_pin_count;
        @(posedge clk_sys) disable iff (!rst_n)
        lcd_out.mode == lupc_pkg::LUPC_TFT_24 |-> lcd_out.pin_count == 5'h1e;
    endproperty
    a_pin_count: assert property (p_pin_count)
        else $error("tft 24-bit pin count wrong");

    property p_stn_count;
        @(posedge clk_sys) disable iff (!rst_n)
        lcd_out.mode == lupc_pkg::LUPC_STN_4 |-> lcd_out.pin_count == 5'h0a;
    endproperty
    a_stn_count: assert property (p_stn_count)
        else $error("stn 4-bit pin count wrong");

    property p_div;
        @(posedge clk_sys) disable iff (!rst_n)
        (panel_src_tick && lcd_out.prescale == 5'h00 && $stable(lcd_out))
        |=> panel_clk_tick;
    endproperty
    a_div: assert property (p_div)
        else $error("divide by one missed a tick");

    property p_modem;
        @(posedge clk_sys) disable iff (!rst_n)
        !uart_reg[lupc_pkg::U3_MODEM_BIT] |=> u3_modem_oe_n
        && u3_to_core == MODEM_IDLE;
    endproperty
    a_modem: assert property (p_modem)
        else $error("modem pins connected while disabled");

    property p_mask;
        @(posedge clk_sys) disable iff (!rst_n)
        (uart_reg[lupc_pkg::U6_BYP_BIT] && uart_reg[lupc_pkg::HDX_EN_BIT]
         && !u6_txd) |=> u6_rxd;
    endproperty
    a_mask: assert property (p_mask)
        else $error("receive not masked during transmit");

    property p_rx_inv;
        @(posedge clk_sys) disable iff (!rst_n)
        (uart_reg[lupc_pkg::U6_BYP_BIT] && !uart_reg[lupc_pkg::HDX_EN_BIT])
        |=> u6_rxd == ($past(u6_ir_rx_pin) ^ $past(uart_reg[3])
                       ^ $past(uart_reg[10]));
    endproperty
    a_rx_inv: assert property (p_rx_inv)
        else $error("receive inversion wrong");

    property p_tx_len;
        @(posedge clk_sys) disable iff (!rst_n)
        (tx_start && tx_pulse_reg == 5'h00 && uart_reg[1])
        |=> tx_pulse_reg == lupc_pkg::IR_FIX_CYC;
    endproperty
    a_tx_len: assert property (p_tx_len)
        else $error("fixed transmit pulse length wrong");

    property p_usb;
        @(posedge clk_sys) disable iff (!rst_n)
        (wr_stb && hit_uart) |=> ##1 usb_dp_oe_n == !$past(pwdata[0], 2);
    endproperty
    a_usb: assert property (p_usb)
        else $error("usb routing does not follow write");

    property p_err;
        @(posedge clk_sys) disable iff (!rst_n)
        (psel && penable && !hit_lcd && !hit_uart) |-> pslverr
        ##1 ($stable(lcd_reg) && $stable(uart_reg));
    endproperty
    a_err: assert property (p_err)
        else $error("unmapped access not refused");

    c_stn: cover property (@(posedge clk_sys) lcd_out.mode[2]);
    c_modem: cover property (@(posedge clk_sys) !u3_modem_oe_n);
    c_irtx: cover property (@(posedge clk_sys) tx_pulse_reg != 5'h00);
    c_usb: cover property (@(posedge clk_sys) !usb_dp_oe_n);
endmodule : lupc_core

// ### testbench/lupc_core_tb.sv
// Register and routing testbench for the LCD and UART pin configuration block
`timescale 1ns/10ps
module lupc_core_tb;
    // ============================================================
    // Signals
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic pready, pslverr, lcd_pin_override, lcd_bus_clk, panel_clk_tick;
    lupc_pkg::lupc_lcd_out_t lcd_out;
    logic panel_src_tick = 1'b0;
    lupc_pkg::lupc_modem_t u3_core_modem = 6'h00, u3_pin_modem = 6'h00;
    lupc_pkg::lupc_modem_t u3_to_core, u3_to_pin;
    logic u3_modem_oe_n, u6_ir_tx_pin, u6_rxd;
    logic u6_txd = 1'b1, u6_baud16_tick = 1'b0, u6_ir_rx_pin = 1'b1;
    logic u5_txd = 1'b1, u5_receive_pin = 1'b1, usb_dm_in = 1'b1;
    logic u5_transmit_pin, u5_rxd, usb_dp_out, usb_dp_oe_n;
    logic tick_run = 1'b0;
    int err_total = 0, n_tests = 0, n_pclk = 0, n_irtx = 0, n_rxlo = 0;
    logic [31:0] rd_v;
    logic rd_e;
    logic [4:0] pins_tab [8] = '{5'h12, 5'h16, 5'h18, 5'h1e,
                                 5'h0a, 5'h0e, 5'h0e, 5'h16};
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        u6_baud16_tick <= tick_run ? ~u6_baud16_tick : 1'b0;
        if (panel_clk_tick === 1'b1) n_pclk++;
        if (u6_ir_tx_pin === 1'b1) n_irtx++;
        if (u6_rxd === 1'b0) n_rxlo++;
    end
    lupc_core dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lcd_out(lcd_out), .lcd_pin_override(lcd_pin_override),
        .lcd_bus_clk(lcd_bus_clk), .panel_src_tick(panel_src_tick),
        .panel_clk_tick(panel_clk_tick), .u3_core_modem(u3_core_modem),
        .u3_pin_modem(u3_pin_modem), .u3_to_core(u3_to_core),
        .u3_to_pin(u3_to_pin), .u3_modem_oe_n(u3_modem_oe_n),
        .u6_txd(u6_txd), .u6_baud16_tick(u6_baud16_tick),
        .u6_ir_rx_pin(u6_ir_rx_pin), .u6_ir_tx_pin(u6_ir_tx_pin),
        .u6_rxd(u6_rxd), .u5_txd(u5_txd), .u5_receive_pin(u5_receive_pin),
        .usb_dm_in(usb_dm_in), .u5_transmit_pin(u5_transmit_pin),
        .u5_rxd(u5_rxd), .usb_dp_out(usb_dp_out), .usb_dp_oe_n(usb_dp_oe_n));
    // ============================================================
    // Tasks
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 100);
        rd_v = prdata;
        rd_e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 100) chk("pready", 32'h1, 32'h0);
    endtask : apb
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    initial begin
        #(100ns * 60000);
        err_total++;
        final_report();
    end
    // ============================================================
    // Tests
    initial begin
        logic [8:0] cfg;
        logic [11:0] uc;
        logic ex_tx, ex_rx;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        cyc(2);
        chk("u3_to_core rst", 32'h3f, 32'(u3_to_core));
        chk("oe rst", 32'h3, {30'h0, u3_modem_oe_n, usb_dp_oe_n});
        apb(1'b0, lupc_pkg::LCD_CONF_ADDR, 32'h0);
        chk("lcd_pin_and_clock_config rst", 32'h0, rd_v);
        apb(1'b0, lupc_pkg::UART_CTL_ADDR, 32'h0);
        chk("uart ctl rst", 32'h0, rd_v);
        apb(1'b1, 32'h4000_4058, 32'h1ff);
        chk("unmapped err", 32'h1, 32'(rd_e));
        apb(1'b0, 32'h4000_4058, 32'h0);
        chk("unmapped rd", 32'h0, rd_v);
        for (int m = 0; m < 8; m++) begin
            cfg = {m[2:0], m[0], 5'(m * 3 + 1)};
            apb(1'b1, lupc_pkg::LCD_CONF_ADDR, 32'(cfg));
            apb(1'b0, lupc_pkg::LCD_CONF_ADDR, 32'h0);
            chk("lcd readback", 32'(cfg), rd_v);
            chk("lcd mode", 32'(m), 32'(lcd_out.mode));
            chk("lcd pins", 32'(pins_tab[m]), 32'(lcd_out.pin_count));
            chk("lcd clk en", 32'(m[0]), 32'(lcd_out.bus_clk_en));
            chk("lcd prescale", 32'(m * 3 + 1), 32'(lcd_out.prescale));
            chk("lcd override", 32'h1, 32'(lcd_pin_override));
        end
        for (int e = 0; e < 2; e++) begin
            apb(1'b1, lupc_pkg::LCD_CONF_ADDR, 32'(e * 32 + 2));
            cyc(3);
            #25;
            chk("bus clk high", 32'(e), 32'(lcd_bus_clk));
            #50;
            chk("bus clk low", 32'h0, 32'(lcd_bus_clk));
        end
        for (int p = 0; p < 3; p += 2) begin
            apb(1'b1, lupc_pkg::LCD_CONF_ADDR, 32'(p));
            cyc(3);
            n_pclk = 0;
            for (int i = 0; i < 12; i++) begin
                @(posedge clk_sys);
                panel_src_tick <= 1'b1;
                @(posedge clk_sys);
                panel_src_tick <= 1'b0;
            end
            cyc(4);
            chk("panel ticks", 32'(12 / (p + 1)), 32'(n_pclk));
        end
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, lupc_pkg::UART_CTL_ADDR, 32'(s * 12'h800));
            for (int k = 0; k < 2; k++) begin
                @(posedge clk_sys);
                u3_core_modem <= k ? 6'h15 : 6'h2a;
                u3_pin_modem <= k ? 6'h2a : 6'h15;
                cyc(3);
                ex_tx = s ? u3_core_modem.dtr : 1'b1;
                chk("u3 dtr pin", 32'(ex_tx), 32'(u3_to_pin.dtr));
                ex_tx = s ? u3_core_modem.rts : 1'b1;
                chk("u3 rts pin", 32'(ex_tx), 32'(u3_to_pin.rts));
                chk("u3 in core", s ? 32'(u3_pin_modem[3:0]) : 32'hf,
                    32'(u3_to_core[3:0]));
                chk("u3 oe_n", 32'(!s), 32'(u3_modem_oe_n));
            end
        end
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, lupc_pkg::UART_CTL_ADDR, 32'(s));
            for (int k = 0; k < 4; k++) begin
                @(posedge clk_sys);
                u5_txd <= k[0];
                u5_receive_pin <= k[1];
                usb_dm_in <= k[0];
                cyc(3);
                chk("u5_transmit_pin pin", 32'(k[0]), 32'(u5_transmit_pin));
                chk("u5 rxd", 32'(k[1] & (k[0] | !s)), 32'(u5_rxd));
                chk("usb oe_n", 32'(!s), 32'(usb_dp_oe_n));
                if (s) chk("usb dp", 32'(k[0]), 32'(usb_dp_out));
            end
        end
        for (int i = 0; i < 16; i++) begin
            uc = {1'b0, i[2], i[3], 3'b000, 1'b1, i[0], i[1], 3'b000};
            apb(1'b1, lupc_pkg::UART_CTL_ADDR, 32'(uc));
            for (int j = 0; j < 4; j++) begin
                @(posedge clk_sys);
                u6_txd <= j[0];
                u6_ir_rx_pin <= j[1];
                cyc(3);
                ex_tx = j[0] ^ i[0];
                ex_rx = (i[3] && !j[0]) ? 1'b1 : (j[1] ^ i[1] ^ i[2]);
                chk("ir tx bypass", 32'(ex_tx), 32'(u6_ir_tx_pin));
                chk("ir rx bypass", 32'(ex_rx), 32'(u6_rxd));
            end
        end
        u6_txd <= 1'b1;
        u6_ir_rx_pin <= 1'b1;
        tick_run <= 1'b1;
        for (int v = 0; v < 2; v++) begin
            apb(1'b1, lupc_pkg::UART_CTL_ADDR, 32'(v * 2));
            cyc(40);
            n_irtx = 0;
            u6_txd <= 1'b0;
            cyc(64);
            u6_txd <= 1'b1;
            cyc(40);
            chk("ir tx pulse", v ? 32'd32 : 32'd12, 32'(n_irtx));
        end
        for (int v = 0; v < 3; v++) begin
            apb(1'b1, lupc_pkg::UART_CTL_ADDR, (v > 0) ? 32'h4 : 32'h0);
            cyc(40);
            n_rxlo = 0;
            u6_ir_rx_pin <= 1'b0;
            cyc(v == 0 ? 3 : (v == 1 ? 10 : 4));
            u6_ir_rx_pin <= 1'b1;
            cyc(60);
            chk("ir rx pulse", (v < 2) ? 32'd30 : 32'd0,
                32'(n_rxlo));
        end
        final_report();
    end
endmodule : lupc_core_tb
